// [hdl/flash_ctrl_pkg.sv]
/*
  Package for the flash control and status block: register indices, field positions,
  reset values, mode codes and timing constants.
  Assumes a byte-wide plain register port on one 20 MHz clock.
*/
package flash_ctrl_pkg;

  // Register indices on the plain port
  localparam logic [2:0] ADDR_PE_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_ERROR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_ERASE_SELECT = 3'h2;
  localparam logic [2:0] ADDR_POWER_CTRL   = 3'h3;
  localparam logic [2:0] ADDR_ACCESS_GATE  = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STATUS   = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK     = 3'h6;
  localparam logic [2:0] ADDR_MODE         = 3'h7;

  // Field positions
  localparam int BIT_ERROR_FLAG      = 7;
  localparam int BIT_POWERDOWN_INHIB = 7;
  localparam int BIT_ACCESS_ENABLE   = 7;
  localparam int BIT_SW_WRITE_EN     = 6;
  localparam int BIT_IRQ_ERROR       = 0;
  localparam int BIT_IRQ_CLEARED     = 1;
  localparam int BIT_IRQ_POWERDOWN   = 2;

  // Reset values
  localparam logic [7:0] RST_PE_CONTROL   = 8'h00;
  localparam logic [7:0] RST_ERASE_SELECT = 8'h00;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [2:0] RST_IRQ          = 3'h0;

  // Erase block map: select bit i picks block i
  localparam logic [15:0] BLK_START [5] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000};
  localparam logic [15:0] BLK_END   [5] = '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF, 16'h7FFF};
  localparam int NUM_BLOCKS = 5;

  // Mode pin setup time before reset release, in states
  localparam int MODE_SETUP_STATES = 4;

  typedef enum logic [1:0] {
    MODE_USER       = 2'b00,
    MODE_BOOT       = 2'b01,
    MODE_PROGRAMMER = 2'b10,
    MODE_UNDEFINED  = 2'b11
  } op_mode_t;

endpackage

// [hdl/flash_ctrl_status.sv]
/*
  Flash control and status: error flag, erase block select, power-down control,
  access gate, mode capture at reset end, sticky interrupts.
  Assumes a single-cycle plain register port; mode pins come from outside and are synchronised.
*/
// What this block does
// - Program/erase failure sets read-only error flag bit 7; error-protection while set.
// - Reserved bits 6..0 of status, power and gate registers read zero.
// - Erase block select held at zero while software write enable is 0.
// - More than one select bit set clears the whole select register.
// - Each select bit picks one erase block: four 1 kbyte, one 28 kbyte.
// - Subactive entry powers flash down unless powerdown inhibit bit is 1.
// - Power-down partly halts flash supply; reads remain allowed.
// - Access gate bit 7 gates CPU access to control, status, select, power registers.
// - Mode from test, interrupt, port pins sampled at reset end.
// - Boot mode runs built-in boot program loading control program then full erase.
// - User mode lets a user control program erase and program single blocks.
// - Write enable 0 blocks setting other control bits and select bits.
`timescale 1ns/100ps
`default_nettype none

module flash_ctrl_status
  import flash_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Flash core status and chip power state
  input  wire logic        pe_fail,
  input  wire logic        subactive,
  // Mode pins
  input  wire logic        test_pin,
  input  wire logic        nmi_pin,
  input  wire logic        port_eight_bit_five,
  input  wire logic        port_b_bit_zero,
  input  wire logic        port_b_bit_one,
  input  wire logic        port_b_bit_two,
  // Flash core controls
  output logic      [7:0]  program_erase_control,
  output logic      [4:0]  erase_block_select,
  output logic             error_protect,
  output logic             flash_powerdown,
  output logic      [1:0]  op_mode,
  output logic             boot_program_start,
  output logic             user_program_allowed,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and mode capture

  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r;
  assign pin_raw = {port_b_bit_two, port_b_bit_one, port_b_bit_zero,
                    port_eight_bit_five, nmi_pin, test_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        pin_s1_r[gi] <= pin_raw[gi];
        pin_s2_r[gi] <= pin_s1_r[gi];
        pin_s3_r[gi] <= pin_s2_r[gi];
        if (pin_s2_r[gi] == pin_s3_r[gi]) begin
          pin_stable_r[gi] <= pin_s3_r[gi];
        end
      end
    end
  endgenerate

  op_mode_t mode_nxt;
  op_mode_t mode_r;
  logic     in_reset_r;

  always_comb begin
    mode_nxt = MODE_UNDEFINED;
    if (!pin_stable_r[0] && pin_stable_r[1]) begin
      mode_nxt = MODE_USER;
    end else if (!pin_stable_r[0] && !pin_stable_r[1] && pin_stable_r[2]) begin
      mode_nxt = MODE_BOOT;
    end else if (pin_stable_r[0] && pin_stable_r[5:3] == 3'h0) begin
      mode_nxt = MODE_PROGRAMMER;
    end
  end

  // Mode caught on the first edge after reset release
  always_ff @(posedge clock) begin
    if (srst) begin
      in_reset_r         <= 1'b1;
      mode_r             <= MODE_UNDEFINED;
      boot_program_start <= 1'b0;
    end else begin
      in_reset_r         <= 1'b0;
      boot_program_start <= 1'b0;
      if (in_reset_r) begin
        mode_r             <= mode_nxt;
        boot_program_start <= (mode_nxt == MODE_BOOT);
      end
    end
  end

  assign op_mode = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  logic       gate_r, inhibit_r, error_r;
  logic [7:0] pe_ctrl_r;
  logic [4:0] sel_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  logic       gated_ok, wr_pe, wr_sel, wr_pwr;
  logic       swe_nxt;
  logic [4:0] sel_wr;

  assign gated_ok = gate_r;
  assign wr_pe    = reg_wr && gated_ok && reg_addr == ADDR_PE_CONTROL;
  assign wr_sel   = reg_wr && gated_ok && reg_addr == ADDR_ERASE_SELECT;
  assign wr_pwr   = reg_wr && gated_ok && reg_addr == ADDR_POWER_CTRL;
  assign swe_nxt  = wr_pe ? reg_wdata[BIT_SW_WRITE_EN] : pe_ctrl_r[BIT_SW_WRITE_EN];
  assign sel_wr   = wr_sel ? reg_wdata[4:0] : sel_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      gate_r <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_ACCESS_GATE) begin
      gate_r <= reg_wdata[BIT_ACCESS_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      inhibit_r <= 1'b0;
    end else if (wr_pwr) begin
      inhibit_r <= reg_wdata[BIT_POWERDOWN_INHIB];
    end
  end

  // Other control bits only settable with write enable
  always_ff @(posedge clock) begin
    if (srst) begin
      pe_ctrl_r <= RST_PE_CONTROL;
    end else if (wr_pe) begin
      pe_ctrl_r <= reg_wdata[BIT_SW_WRITE_EN] ? {1'b0, reg_wdata[6:0]} : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sel_r <= RST_ERASE_SELECT[4:0];
    end else if (!swe_nxt) begin
      sel_r <= RST_ERASE_SELECT[4:0];
    end else if ($countones(sel_wr) > 1) begin
      sel_r <= RST_ERASE_SELECT[4:0];
    end else begin
      sel_r <= sel_wr;
    end
  end

  // Error status is read-only; writes are ignored
  always_ff @(posedge clock) begin
    if (srst) begin
      error_r <= 1'b0;
    end else if (pe_fail) begin
      error_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to flash core

  always_ff @(posedge clock) begin
    if (srst) begin
      program_erase_control <= RST_PE_CONTROL;
      erase_block_select    <= RST_ERASE_SELECT[4:0];
      error_protect         <= 1'b0;
      flash_powerdown       <= 1'b0;
      user_program_allowed  <= 1'b0;
    end else begin
      program_erase_control <= pe_ctrl_r;
      erase_block_select    <= sel_r;
      error_protect         <= error_r;
      flash_powerdown       <= subactive && !inhibit_r;
      user_program_allowed  <= (mode_r == MODE_USER) && !error_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [2:0] irq_evt;
  logic       err_rise;
  logic       pd_rise;
  logic       error_d_r, pd_d_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      error_d_r <= 1'b0;
      pd_d_r    <= 1'b0;
    end else begin
      error_d_r <= error_r;
      pd_d_r    <= flash_powerdown;
    end
  end

  assign err_rise = error_r && !error_d_r;
  assign pd_rise  = flash_powerdown && !pd_d_r;
  assign irq_evt  = {pd_rise, wr_sel && ($countones(sel_wr) > 1), err_rise};

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_stat_r <= RST_IRQ;
    end else begin
      if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_mask_r <= RST_IRQ;
    end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PE_CONTROL:   reg_rdata <= gated_ok ? pe_ctrl_r : 8'h00;
        ADDR_ERROR_STATUS: reg_rdata <= gated_ok ? {error_r, 7'h00} : 8'h00;
        ADDR_ERASE_SELECT: reg_rdata <= gated_ok ? {3'h0, sel_r} : 8'h00;
        ADDR_POWER_CTRL:   reg_rdata <= gated_ok ? {inhibit_r, 7'h00} : 8'h00;
        ADDR_ACCESS_GATE:  reg_rdata <= {gate_r, 7'h00};
        ADDR_IRQ_STATUS:   reg_rdata <= {5'h00, irq_stat_r};
        ADDR_IRQ_MASK:     reg_rdata <= {5'h00, irq_mask_r};
        ADDR_MODE:         reg_rdata <= {6'h00, mode_r};
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_error_sticky;
    @(posedge clock) disable iff (srst) pe_fail |=> error_r ##1 error_protect;
  endproperty
  a_error_sticky: assert property (p_error_sticky) else $error("error flag not set");

  property p_status_reserved;
    @(posedge clock) disable iff (srst)
      reg_rd && reg_addr == ADDR_ERROR_STATUS |=> reg_rdata[6:0] == 7'h00;
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("reserved bits nonzero");

  property p_sel_zero_no_swe;
    @(posedge clock) disable iff (srst) !pe_ctrl_r[BIT_SW_WRITE_EN] |-> sel_r == 5'h00;
  endproperty
  a_sel_zero_no_swe: assert property (p_sel_zero_no_swe) else $error("select set without enable");

  property p_sel_onehot;
    @(posedge clock) disable iff (srst) $countones(sel_r) <= 1;
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("select not one-hot");

  property p_powerdown;
    @(posedge clock) disable iff (srst)
      subactive && !inhibit_r ##1 !srst |-> flash_powerdown;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("power-down not entered");

  property p_gate_blocks;
    @(posedge clock) disable iff (srst)
      !gate_r && reg_rd && reg_addr == ADDR_POWER_CTRL |=> reg_rdata == 8'h00;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("gated read leaked");

  property p_mode_hold;
    @(posedge clock) disable iff (srst) !in_reset_r |=> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

  property p_pe_needs_swe;
    @(posedge clock) disable iff (srst) pe_ctrl_r != 8'h00 |-> pe_ctrl_r[BIT_SW_WRITE_EN];
  endproperty
  a_pe_needs_swe: assert property (p_pe_needs_swe) else $error("control bit without enable");

endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench for the flash control and status block: register port
  accesses, erase select, power-down, error flag, interrupts and mode capture.
  Assumes the design package is compiled first and one 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench
  import flash_ctrl_pkg::*;
;
  logic       clock;
  logic       srst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       pe_fail;
  logic       subactive;
  logic       test_pin;
  logic       nmi_pin;
  logic       port_eight_bit_five;
  logic [2:0] port_b;
  logic [7:0] program_erase_control;
  logic [4:0] erase_block_select;
  logic       error_protect;
  logic       flash_powerdown;
  logic [1:0] op_mode;
  logic       boot_program_start;
  logic       user_program_allowed;
  logic       irq;
  int         n_errors;
  int         n_compared;
  logic [7:0] rd_val;

  flash_ctrl_status dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pe_fail(pe_fail),
    .subactive(subactive), .test_pin(test_pin), .nmi_pin(nmi_pin),
    .port_eight_bit_five(port_eight_bit_five), .port_b_bit_zero(port_b[0]),
    .port_b_bit_one(port_b[1]), .port_b_bit_two(port_b[2]),
    .program_erase_control(program_erase_control), .erase_block_select(erase_block_select),
    .error_protect(error_protect), .flash_powerdown(flash_powerdown), .op_mode(op_mode),
    .boot_program_start(boot_program_start), .user_program_allowed(user_program_allowed),
    .irq(irq)
  );

  always #25 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    if (a == ADDR_ERROR_STATUS) begin
      n_errors++;
      $display("MISMATCH at %0t: write issued to read-only status", $time);
    end
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk_byte(reg_rdata, exp);
  endtask

  // Reset with mode pins already settled
  task automatic do_reset(input logic t, input logic n, input logic p85, input logic [2:0] pb);
    @(posedge clock);
    test_pin            <= t;
    nmi_pin             <= n;
    port_eight_bit_five <= p85;
    port_b              <= pb;
    srst                <= 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic wait_irq(input logic exp);
    int k;
    for (k = 0; k < 8 && irq !== exp; k++) begin
      @(posedge clock);
      #1;
    end
    if (irq !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: interrupt wait ran out", $time);
      end_of_test();
    end
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    $display("MISMATCH at %0t: run too long", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0; srst = 1'b1; reg_addr = 3'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; pe_fail = 1'b0; subactive = 1'b0;
    test_pin = 1'b0; nmi_pin = 1'b1; port_eight_bit_five = 1'b0; port_b = 3'h7;
    n_errors = 0; n_compared = 0;
    do_reset(1'b0, 1'b1, 1'b0, 3'h7);
    chk_byte({6'h00, op_mode}, {6'h00, MODE_USER});
    chk_bit(boot_program_start, 1'b0);
    reg_read(ADDR_ACCESS_GATE, 8'h00);
    chk_bit(user_program_allowed, 1'b1);
    reg_read(ADDR_MODE, {6'h00, MODE_USER});
    // Gate closed: write dropped
    reg_write(ADDR_POWER_CTRL, 8'h80);
    reg_write(ADDR_ACCESS_GATE, 8'hFF);
    reg_read(ADDR_ACCESS_GATE, 8'h80);
    reg_read(ADDR_POWER_CTRL, 8'h00);
    reg_read(ADDR_ERROR_STATUS, 8'h00);
    // Power-down on subactive entry
    reg_write(ADDR_POWER_CTRL, 8'hFF);
    reg_read(ADDR_POWER_CTRL, 8'h80);
    subactive <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_bit(flash_powerdown, 1'b0);
    reg_write(ADDR_POWER_CTRL, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk_bit(flash_powerdown, 1'b1);
    reg_read(ADDR_ERROR_STATUS, 8'h00);
    reg_read(ADDR_IRQ_STATUS, 8'h04);
    reg_write(ADDR_IRQ_STATUS, 8'h04);
    subactive <= 1'b0;
    // Erase block select
    reg_write(ADDR_ERASE_SELECT, 8'h01);
    reg_read(ADDR_ERASE_SELECT, 8'h00);
    // Control bits dropped without write enable, bits 6..0 kept with it
    reg_write(ADDR_PE_CONTROL, 8'h3F);
    reg_read(ADDR_PE_CONTROL, 8'h00);
    reg_write(ADDR_PE_CONTROL, 8'hFF);
    reg_read(ADDR_PE_CONTROL, 8'h7F);
    chk_byte(program_erase_control, 8'h7F);
    reg_write(ADDR_PE_CONTROL, 8'h40);
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      reg_write(ADDR_ERASE_SELECT, 8'h01 << i);
      reg_read(ADDR_ERASE_SELECT, 8'h01 << i);
      chk_byte({3'h0, erase_block_select}, 8'h01 << i);
    end
    reg_write(ADDR_ERASE_SELECT, 8'h18);
    reg_read(ADDR_ERASE_SELECT, 8'h00);
    reg_read(ADDR_IRQ_STATUS, 8'h02);
    reg_write(ADDR_IRQ_STATUS, 8'h02);
    reg_write(ADDR_ERASE_SELECT, 8'h04);
    reg_write(ADDR_PE_CONTROL, 8'h00);
    reg_read(ADDR_ERASE_SELECT, 8'h00);
    chk_byte({3'h0, erase_block_select}, 8'h00);
    // Error flag and interrupt
    reg_write(ADDR_IRQ_MASK, 8'h01);
    chk_bit(irq, 1'b0);
    @(posedge clock);
    pe_fail <= 1'b1;
    @(posedge clock);
    pe_fail <= 1'b0;
    wait_irq(1'b1);
    reg_read(ADDR_ERROR_STATUS, 8'h80);
    chk_bit(error_protect, 1'b1);
    chk_bit(user_program_allowed, 1'b0);
    reg_read(ADDR_ERROR_STATUS, 8'h80);
    reg_write(ADDR_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    // Gate closed hides a set flag and a set inhibit bit
    reg_write(ADDR_POWER_CTRL, 8'h80);
    reg_write(ADDR_ACCESS_GATE, 8'h00);
    reg_read(ADDR_ERROR_STATUS, 8'h00);
    reg_read(ADDR_POWER_CTRL, 8'h00);
    // Boot, programmer and undefined pin settings
    do_reset(1'b0, 1'b0, 1'b1, 3'h7);
    chk_bit(boot_program_start, 1'b1);
    chk_byte({6'h00, op_mode}, {6'h00, MODE_BOOT});
    chk_bit(error_protect, 1'b0);
    do_reset(1'b1, 1'b1, 1'b1, 3'h0);
    chk_byte({6'h00, op_mode}, {6'h00, MODE_PROGRAMMER});
    do_reset(1'b1, 1'b0, 1'b0, 3'h1);
    chk_byte({6'h00, op_mode}, {6'h00, MODE_UNDEFINED});
    end_of_test();
  end
endmodule

`default_nettype wire
